// File: verilog/asr_pkg.sv
// Shared constants for the conversion sequencer and its result queue.
// Assumes a single system clock; all counts are in clock cycles.
package asr_pkg;

  // Word addresses on the parallel bus (index 0..7 is instruction memory)
  localparam logic [3:0] ADDR_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_INT_EN = 4'h9;
  localparam logic [3:0] ADDR_INT_STAT = 4'ha;
  localparam logic [3:0] ADDR_TIMER = 4'hb;
  localparam logic [3:0] ADDR_FIFO = 4'hc;
  localparam int unsigned ADDR_IRAM_BIT = 3;

  // Configuration bits
  localparam int unsigned CFG_START = 0;
  localparam int unsigned CFG_RESET = 1;
  localparam int unsigned CFG_CAL_AZ = 2;
  localparam int unsigned CFG_CAL_FULL = 3;
  localparam int unsigned CFG_TAG_IP = 5;
  localparam int unsigned CFG_AZ_EACH = 6;
  localparam logic [15:0] CFG_RESET_VAL = 16'h0000;

  // Instruction word fields
  localparam int unsigned INS_PAUSE = 0;
  localparam int unsigned INS_LOOP = 1;
  localparam int unsigned INS_REDUCED = 8;
  localparam int unsigned INS_TIMER = 9;
  localparam int unsigned INS_WATCH = 11;
  localparam int unsigned INS_ACQ_LSB = 12;
  localparam int unsigned INS_ACQ_W = 4;

  // Interrupt enable and status layout
  localparam int unsigned IEN_IP_LSB = 8;
  localparam int unsigned IEN_THR_LSB = 11;
  localparam int unsigned FLAG_IP = 1;
  localparam int unsigned FLAG_FIFO = 2;
  localparam int unsigned FLAG_CAL_AZ = 3;
  localparam int unsigned FLAG_CAL_FULL = 4;
  localparam int unsigned FLAG_PAUSE = 5;

  // Result entry layout
  localparam int unsigned RES_SIGN = 12;
  localparam int unsigned RES_TOP_LSB = 13;
  localparam logic [3:0] RES_LOW_PAD = 4'he;

  // Queue shape
  localparam int unsigned FIFO_WIDTH = 16;
  localparam int unsigned FIFO_DEPTH = 32;

  // State durations in clock cycles
  localparam int unsigned CNT_W = 21;
  localparam logic [20:0] CNT_ONE = 21'h1;
  localparam logic [20:0] CAL_SHORT_CYC = 21'h4c;
  localparam int unsigned CAL_LONG_CYC = 4944;
  localparam logic [20:0] TIMER_ADD_CYC = 21'h2;
  localparam logic [20:0] ACQ_FULL_BASE = 21'h9;
  localparam logic [20:0] ACQ_RED_BASE = 21'h2;
  localparam logic [20:0] CMP1_CYC = 21'h5;
  localparam logic [20:0] LIM2_CYC = 21'h1;
  localparam logic [20:0] CONV_FULL_CYC = 21'h2c;
  localparam logic [20:0] CONV_RED_CYC = 21'h15;
  localparam logic [20:0] CONV_WATCH_CYC = 21'h5;

  typedef enum logic [7:0] {
    ST_FETCH = 8'h01,
    ST_REST  = 8'h02,
    ST_CAL   = 8'h04,
    ST_DELAY = 8'h08,
    ST_ACQ   = 8'h10,
    ST_CMP1  = 8'h20,
    ST_LIM2  = 8'h40,
    ST_CONV  = 8'h80
  } asr_state_e;

endpackage

// File: verilog/asr_result_fifo.sv
// Result queue storage: parameterised FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap on their own.
`timescale 1ns/1ns
module asr_result_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32,
  localparam int unsigned AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  // Fill level
  output logic [AW:0] count_out
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } asr_fifo_s;

  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  asr_fifo_s q;
  asr_fifo_s next_q;
  logic push;
  logic pop;

  always_comb
  begin
    next_q = q;
    out_valid_out = q.cnt != '0;
    // A pop in the same cycle frees the slot, so a full queue still accepts
    in_ready_out = (q.cnt != FULL_CNT) || out_ready_in;
    out_data_out = q.mem[q.rd];
    count_out = q.cnt;
    push = in_valid_in && in_ready_out;
    pop = out_ready_in && out_valid_out;
    if (push)
    begin
      next_q.mem[q.wr] = in_data_in;
      next_q.wr = q.wr + 1'b1;
    end
    if (pop)
    begin
      next_q.rd = q.rd + 1'b1;
    end
    if (push && !pop)
    begin
      next_q.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_q.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      q.wr <= '0;
      q.rd <= '0;
      q.cnt <= '0;
      q.mem <= q.mem;
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule

// File: verilog/asr_sequencer.sv
// Conversion sequencer with instruction memory, registers and result queue.
// Assumes an asynchronous parallel host bus (pins synchronised here) and a
// converter core on the same clock presenting its result on conv_data_in.
//
// Overview of operation
// - Read-only 32 x 16 result queue at 1100
// - Bits 3..0 hold low bits or 1110
// - Bits 11..4 magnitude, bit 12 sign
// - Config bit 5 picks sign copies or pointer
// - Push into full queue drops the oldest
// - Eight-bit bus: low byte first, high pops
// - Threshold 11111 interrupts after 31st result
// - Start cleared mid-conversion finishes and stores it
// - Only pause, start low, reset stop sequencer
// - Pointer cleared on reset and loop bit
// - Pointer counts to 111 then wraps
// - Pointer readable in status bits 10..8
// - Fetch reads instruction word in one cycle
// - Rest state holds when stopped, else one cycle
// - Calibration 76 or 4944 cycles per config
// - Delay state lasts 32T plus 2 cycles
// - Acquisition 9+2D or 2+2D cycles
// - First comparison takes five cycles
// - Second limit fetch takes one cycle
// - Conversion 44, 21 or 5 cycles
// - Delay state only when instruction bit 9 set
// - Status read clears all set flags (low byte only on eight-bit bus)
`timescale 1ns/1ns
module asr_sequencer #(
  parameter int unsigned CAL_LONG_CYC = asr_pkg::CAL_LONG_CYC,
  parameter int unsigned FIFO_DEPTH = asr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host bus pins
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic bus_width_select_in,
  input wire logic byte_select_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  // Host signalling
  output logic int_n_out,
  output logic dma_req_out,
  // Converter core
  input wire logic [12:0] conv_data_in,
  output logic conv_active_out
);

  localparam int unsigned CW = asr_pkg::CNT_W;
  localparam int unsigned QW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [QW-1:0] FULL_CNT = QW'(FIFO_DEPTH);
  localparam logic [CW-1:0] CAL_LONG_M1 = CW'(CAL_LONG_CYC - 1);

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic bw8;
    logic bsel;
    logic [3:0] addr;
    logic [15:0] data;
  } asr_pins_s;

  typedef struct packed {
    asr_pins_s s1;
    asr_pins_s s2;
    logic rd_prev;
    logic wr_prev;
    logic [7:0][15:0] iram;
    logic [15:0] cfg;
    logic [15:0] ien;
    logic [7:0] flags;
    logic [15:0] timer;
    logic [2:0] instruction_pointer;
    logic [15:0] instr;
    asr_pkg::asr_state_e state;
    logic [CW-1:0] cnt;
    logic pause_done;
    logic [QW-1:0] prev_count;
    logic [15:0] rdata;
    logic oe;
    logic int_n;
    logic dma;
    logic conv;
  } asr_seq_s;

  asr_seq_s q;
  asr_seq_s next_q;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_ready;
  logic fifo_valid;
  logic [15:0] fifo_head;
  logic [QW-1:0] fifo_count;
  logic [15:0] result;
  logic [15:0] rword;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic rd_act;
  logic wr_act;
  logic watch;
  logic reduced;
  logic [CW-1:0] acq_m1;
  logic [CW-1:0] conv_m1;
  logic [CW-1:0] delay_m1;
  logic [2:0] ip_next;

  // Byte lane merge for writes on the eight-bit bus
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic bw8,
                                        input logic bsel);
    logic [15:0] r;
    r = d;
    if (bw8)
    begin
      r = bsel ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]};
    end
    return r;
  endfunction

  asr_result_fifo #(
    .WIDTH(asr_pkg::FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_ready),
    .in_data_in(result),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_head),
    .count_out(fifo_count)
  );

  always_comb
  begin
    next_q = q;
    flag_set = '0;
    flag_clr = '0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    rword = '0;
    next_q.s1 = {cs_n_in, rd_n_in, wr_n_in, bus_width_select_in,
                 byte_select_in, addr_in, data_in};
    next_q.s2 = q.s1;
    rd_act = !q.s2.cs_n && !q.s2.rd_n;
    wr_act = !q.s2.cs_n && !q.s2.wr_n;
    next_q.rd_prev = rd_act;
    next_q.wr_prev = wr_act;
    watch = q.instr[asr_pkg::INS_WATCH];
    reduced = q.instr[asr_pkg::INS_REDUCED];
    acq_m1 = ((reduced || watch) ? asr_pkg::ACQ_RED_BASE
                                 : asr_pkg::ACQ_FULL_BASE)
             + CW'({q.instr[asr_pkg::INS_ACQ_LSB +: asr_pkg::INS_ACQ_W],
                    1'b0})
             - asr_pkg::CNT_ONE;
    conv_m1 = (watch ? asr_pkg::CONV_WATCH_CYC
               : reduced ? asr_pkg::CONV_RED_CYC
               : asr_pkg::CONV_FULL_CYC) - asr_pkg::CNT_ONE;
    // Timer value scaled by the 5-bit prescaler
    delay_m1 = {q.timer, 5'h00} + asr_pkg::TIMER_ADD_CYC
               - asr_pkg::CNT_ONE;
    ip_next = q.instr[asr_pkg::INS_LOOP] ? 3'h0
              : q.instruction_pointer + 3'h1;

    // Result entry assembly
    result[15:0] = {{3{conv_data_in[asr_pkg::RES_SIGN]}}, conv_data_in};
    if (reduced)
    begin
      result[3:0] = asr_pkg::RES_LOW_PAD;
    end
    if (q.cfg[asr_pkg::CFG_TAG_IP])
    begin
      result[15:asr_pkg::RES_TOP_LSB] = q.instruction_pointer;
    end

    // Register read data
    case (q.s2.addr)
      asr_pkg::ADDR_CONFIG: rword = q.cfg;
      asr_pkg::ADDR_INT_EN: rword = q.ien;
      asr_pkg::ADDR_INT_STAT: rword = {fifo_count[4:0],
                                       q.instruction_pointer,
                                       q.flags};
      asr_pkg::ADDR_TIMER: rword = q.timer;
      asr_pkg::ADDR_FIFO: rword = fifo_valid ? fifo_head : 16'h0000;
      default:
      begin
        if (!q.s2.addr[asr_pkg::ADDR_IRAM_BIT])
        begin
          rword = q.iram[q.s2.addr[2:0]];
        end
      end
    endcase

    // Bus read: data latched at the start of the strobe
    next_q.oe = rd_act;
    if (rd_act && !q.rd_prev)
    begin
      next_q.rdata = rword;
      if (q.s2.bw8)
      begin
        next_q.rdata = {8'h00, q.s2.bsel ? rword[15:8] : rword[7:0]};
      end
      // Only the high-byte (or whole-word) read advances the queue, so a
      // high byte read first shifts the queue and the low byte is lost
      if (q.s2.addr == asr_pkg::ADDR_FIFO && fifo_valid &&
          (!q.s2.bw8 || q.s2.bsel))
      begin
        fifo_pop = 1'b1;
      end
      if (q.s2.addr == asr_pkg::ADDR_INT_STAT && (!q.s2.bw8 || !q.s2.bsel))
      begin
        flag_clr = '1;
      end
    end

    // Bus write
    if (wr_act && !q.wr_prev)
    begin
      case (q.s2.addr)
        asr_pkg::ADDR_CONFIG:
          next_q.cfg = merge(q.cfg, q.s2.data, q.s2.bw8, q.s2.bsel);
        asr_pkg::ADDR_INT_EN:
          next_q.ien = merge(q.ien, q.s2.data, q.s2.bw8, q.s2.bsel);
        asr_pkg::ADDR_TIMER:
          next_q.timer = merge(q.timer, q.s2.data, q.s2.bw8, q.s2.bsel);
        default:
        begin
          if (!q.s2.addr[asr_pkg::ADDR_IRAM_BIT])
          begin
            next_q.iram[q.s2.addr[2:0]] = merge(q.iram[q.s2.addr[2:0]],
                                                q.s2.data, q.s2.bw8,
                                                q.s2.bsel);
          end
        end
      endcase
    end

    // Sequencer
    if (q.cnt != '0)
    begin
      next_q.cnt = q.cnt - asr_pkg::CNT_ONE;
    end
    case (q.state)
      asr_pkg::ST_FETCH:
      begin
        next_q.instr = q.iram[q.instruction_pointer];
        next_q.state = asr_pkg::ST_REST;
      end
      asr_pkg::ST_REST:
      begin
        // Start is only sampled here, so clearing it never cuts a conversion
        if (next_q.cfg[asr_pkg::CFG_START] &&
            !next_q.cfg[asr_pkg::CFG_RESET])
        begin
          if (q.instr[asr_pkg::INS_PAUSE] && !q.pause_done)
          begin
            next_q.cfg[asr_pkg::CFG_START] = 1'b0;
            next_q.pause_done = 1'b1;
            flag_set[asr_pkg::FLAG_PAUSE] = 1'b1;
          end
          else if (q.cfg[asr_pkg::CFG_CAL_AZ] ||
                   q.cfg[asr_pkg::CFG_CAL_FULL] ||
                   q.cfg[asr_pkg::CFG_AZ_EACH])
          begin
            next_q.pause_done = 1'b0;
            next_q.state = asr_pkg::ST_CAL;
            next_q.cnt = q.cfg[asr_pkg::CFG_CAL_FULL] ? CAL_LONG_M1
                         : asr_pkg::CAL_SHORT_CYC
                           - asr_pkg::CNT_ONE;
          end
          else if (q.instr[asr_pkg::INS_TIMER])
          begin
            next_q.pause_done = 1'b0;
            next_q.state = asr_pkg::ST_DELAY;
            next_q.cnt = delay_m1;
          end
          else
          begin
            next_q.pause_done = 1'b0;
            next_q.state = asr_pkg::ST_ACQ;
            next_q.cnt = acq_m1;
          end
        end
        else
        begin
          // Parked: refetch so words written while stopped are the ones run
          next_q.instr = q.iram[q.instruction_pointer];
        end
      end
      asr_pkg::ST_CAL:
      begin
        if (q.cnt == '0)
        begin
          flag_set[asr_pkg::FLAG_CAL_FULL] = q.cfg[asr_pkg::CFG_CAL_FULL];
          flag_set[asr_pkg::FLAG_CAL_AZ] = !q.cfg[asr_pkg::CFG_CAL_FULL] &&
                                           q.cfg[asr_pkg::CFG_CAL_AZ];
          // One-shot calibration requests clear themselves when done
          next_q.cfg[asr_pkg::CFG_CAL_AZ] = 1'b0;
          next_q.cfg[asr_pkg::CFG_CAL_FULL] = 1'b0;
          next_q.state = q.instr[asr_pkg::INS_TIMER] ? asr_pkg::ST_DELAY
                         : asr_pkg::ST_ACQ;
          next_q.cnt = q.instr[asr_pkg::INS_TIMER] ? delay_m1 : acq_m1;
        end
      end
      asr_pkg::ST_DELAY:
      begin
        if (q.cnt == '0)
        begin
          next_q.state = asr_pkg::ST_ACQ;
          next_q.cnt = acq_m1;
        end
      end
      asr_pkg::ST_ACQ:
      begin
        if (q.cnt == '0)
        begin
          next_q.state = watch ? asr_pkg::ST_CMP1 : asr_pkg::ST_CONV;
          next_q.cnt = watch ? asr_pkg::CMP1_CYC - asr_pkg::CNT_ONE
                       : conv_m1;
        end
      end
      asr_pkg::ST_CMP1:
      begin
        if (q.cnt == '0)
        begin
          next_q.state = asr_pkg::ST_LIM2;
          next_q.cnt = asr_pkg::LIM2_CYC - asr_pkg::CNT_ONE;
        end
      end
      asr_pkg::ST_LIM2:
      begin
        if (q.cnt == '0)
        begin
          next_q.state = asr_pkg::ST_CONV;
          next_q.cnt = conv_m1;
        end
      end
      asr_pkg::ST_CONV:
      begin
        if (q.cnt == '0)
        begin
          fifo_push = !watch;
          next_q.instruction_pointer = ip_next;
          flag_set[asr_pkg::FLAG_IP] =
            ip_next == q.ien[asr_pkg::IEN_IP_LSB +: 3];
          next_q.state = asr_pkg::ST_FETCH;
        end
      end
      default:
      begin
        next_q.state = asr_pkg::ST_FETCH;
      end
    endcase

    // Full queue: drop the oldest entry to make room for the newest
    if (fifo_push && fifo_count == FULL_CNT)
    begin
      fifo_pop = 1'b1;
    end

    // Threshold reached on a rising fill level
    next_q.prev_count = fifo_count;
    if (fifo_count > q.prev_count &&
        fifo_count == {1'b0, q.ien[asr_pkg::IEN_THR_LSB +: 5]})
    begin
      flag_set[asr_pkg::FLAG_FIFO] = 1'b1;
      if (q.ien[asr_pkg::FLAG_FIFO] && !q.flags[asr_pkg::FLAG_FIFO])
      begin
        next_q.dma = 1'b1;
      end
    end
    if (fifo_count == '0)
    begin
      next_q.dma = 1'b0;
    end

    // A flag raised in the cycle of a status read survives the clear
    next_q.flags = (q.flags & ~flag_clr) | flag_set;

    // Reset bit parks the sequencer and clears pointer and flags
    if (next_q.cfg[asr_pkg::CFG_RESET])
    begin
      next_q.state = asr_pkg::ST_FETCH;
      next_q.instruction_pointer = 3'h0;
      next_q.cnt = '0;
      next_q.pause_done = 1'b0;
      next_q.flags = '0;
      next_q.dma = 1'b0;
    end
    next_q.int_n = !(|(next_q.flags & q.ien[7:0]));
    next_q.conv = next_q.state == asr_pkg::ST_CONV;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
      q.rd_prev <= 1'b0;
      q.wr_prev <= 1'b0;
      q.cfg <= asr_pkg::CFG_RESET_VAL;
      q.state <= asr_pkg::ST_FETCH;
      q.instruction_pointer <= 3'h0;
      q.int_n <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign data_out = q.rdata;
  assign data_oe_out = q.oe;
  assign int_n_out = q.int_n;
  assign dma_req_out = q.dma;
  assign conv_active_out = q.conv;

endmodule

// File: dv/asr_sequencer_sva.sv
// Checker for bus answer timing and conversion state timing of the sequencer.
// Assumes only the top ports are visible and a single system clock.
`timescale 1ns/1ns
module asr_sequencer_sva (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host bus
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_out,
  // Signalling and converter
  input wire logic int_n_out,
  input wire logic dma_req_out,
  input wire logic conv_active_out
);
  logic [5:0] run_len;

  // Counts a conversion run; too long to unroll as a repetition
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !conv_active_out)
      run_len <= 6'h0;
    else
      run_len <= run_len + 6'h1;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_reset_quiet: assert property ($fell(rst_in) |-> !data_oe_out &&
    int_n_out && !dma_req_out && !conv_active_out)
    else $error("outputs not quiet after reset");
  chk_oe_from_read: assert property ($rose(data_oe_out) |->
    !$past(rd_n_in, 2) && !$past(cs_n_in, 2))
    else $error("bus driven without a read strobe");
  chk_oe_release: assert property ($fell(data_oe_out) |->
    $past(rd_n_in, 2) || $past(cs_n_in, 2))
    else $error("bus released while strobe low");
  chk_read_data_hold: assert property (
    data_oe_out && $past(data_oe_out) |-> $stable(data_out))
    else $error("read data changed while driven");
  chk_conv_min_len: assert property (
    $rose(conv_active_out) |-> conv_active_out[*5])
    else $error("conversion shorter than five cycles");
  chk_conv_max_len: assert property (
    conv_active_out |-> run_len < 6'h2c)
    else $error("conversion longer than 44 cycles");
  chk_conv_gap_min: assert property (
    $fell(conv_active_out) |-> !conv_active_out[*4])
    else $error("next conversion too soon");
  chk_dma_with_int: assert property (
    $rose(dma_req_out) |-> ##[0:1] !int_n_out)
    else $error("dma request without interrupt");

  cover property ($rose(dma_req_out));
  cover property ($fell(conv_active_out));
  cover property ($rose(data_oe_out));
endmodule

bind asr_sequencer asr_sequencer_sva i_sva (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .cs_n_in(cs_n_in),
  .rd_n_in(rd_n_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .int_n_out(int_n_out),
  .dma_req_out(dma_req_out),
  .conv_active_out(conv_active_out)
);

// File: dv/asr_host_model.sv
// Host processor model driving the asynchronous parallel bus pins.
// Assumes the bench calls strobe; read data is taken by the bench monitor.
`timescale 1ns/1ns
module asr_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Bus pins toward the device
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic bus_width_select_out,
  output logic byte_select_out,
  output logic [3:0] addr_out,
  output logic [15:0] data_out
);
  initial
  begin
    cs_n_out = 1'h1;
    rd_n_out = 1'h1;
    wr_n_out = 1'h1;
    bus_width_select_out = 1'h0;
    byte_select_out = 1'h0;
    addr_out = 4'h0;
    data_out = 16'h0;
  end

  // Six edges low covers the two-flop sync; qualifiers held throughout
  task automatic strobe(input logic wr, input logic [3:0] a,
                        input logic [15:0] d, input logic bw8,
                        input logic bs);
    @(posedge clk_sys_in);
    cs_n_out <= 1'h0;
    rd_n_out <= wr;
    wr_n_out <= !wr;
    addr_out <= a;
    bus_width_select_out <= bw8;
    byte_select_out <= bs;
    if (wr)
      data_out <= d;
    repeat (6) @(posedge clk_sys_in);
    cs_n_out <= 1'h1;
    rd_n_out <= 1'h1;
    wr_n_out <= 1'h1;
    data_out <= ~d;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule

// File: dv/adc_sequencer_result_fifo_tb_top.sv
// Bench for the sequencer: host model on the bus, bench as converter core.
// Assumes a 100 MHz clock and shortened full calibration.
`timescale 1ns/1ns
module adc_sequencer_result_fifo_tb_top;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic cs_n, rd_n, wr_n, bw8, bsel;
  logic [3:0] addr;
  logic [15:0] wdata, data_out, e_t, m_t;
  logic data_oe_out, int_n_out, dma_req_out, conv_active_out;
  logic [12:0] conv_data_in = 13'h0;
  logic [15:0] exp_q[$], mask_q[$], res_q[$];
  logic [15:0] ins[3];
  logic [15:0] tmr;
  logic tag_ip = 1'h1;
  logic prev_oe = 1'h0;
  logic prev_act = 1'h0;
  int num_errors = 0;
  int num_checks = 0;
  int rises = 0;
  int falls = 0;
  int run = 0;
  int low = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  asr_host_model i_host (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .bus_width_select_out(bw8),
    .byte_select_out(bsel), .addr_out(addr), .data_out(wdata));

  asr_sequencer #(.CAL_LONG_CYC(40)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .bus_width_select_in(bw8), .byte_select_in(bsel), .addr_in(addr),
    .data_in(wdata), .data_out(data_out), .data_oe_out(data_oe_out),
    .int_n_out(int_n_out), .dma_req_out(dma_req_out),
    .conv_data_in(conv_data_in), .conv_active_out(conv_active_out));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic note(input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
  endtask

  task automatic wait_for(ref int cnt, input int n);
    int k;
    for (k = 0; k < 20000 && cnt < n; k++)
      @(posedge clk_sys_in);
    if (cnt < n)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  function automatic int gap(input int k);
    int acq;
    acq = (k == 1 ? 2 : 9) + 2 * int'(ins[k][15:12]);
    return 2 + acq + (ins[k][9] ? 32 * int'(tmr) + 2 : 0);
  endfunction

  // Converter core: result held steady for the whole conversion
  always @(posedge clk_sys_in)
  begin
    if (conv_active_out !== 1'h1)
      conv_data_in <= 13'($urandom);
  end

  always @(posedge clk_sys_in)
  begin
    if (data_oe_out === 1'h1 && prev_oe === 1'h0)
    begin
      if (exp_q.size() > 0)
      begin
        e_t = exp_q.pop_front();
        m_t = mask_q.pop_front();
        check(data_out & m_t, e_t);
      end
      else
      begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=none", $time, data_out);
      end
    end
    if (conv_active_out === 1'h1 && prev_act === 1'h0)
    begin
      if (rises > 0)
        check_cnt(low, gap(rises % 3));
      if (rises == 30)
        check({15'h0, int_n_out}, 16'h1);
      if (rises == 31)
        check({14'h0, int_n_out, dma_req_out}, 16'h1);
      rises++;
      run = 1;
    end
    else if (conv_active_out === 1'h1)
      run++;
    else if (prev_act === 1'h1)
    begin
      check_cnt(run, (falls % 3 == 1) ? 21 : 44);
      e_t[15:13] = tag_ip ? 3'(falls % 3) : {3{conv_data_in[12]}};
      e_t[12:4] = conv_data_in[12:4];
      e_t[3:0] = (falls % 3 == 1) ? asr_pkg::RES_LOW_PAD : conv_data_in[3:0];
      if (res_q.size() == 32)
        void'(res_q.pop_front());
      res_q.push_back(e_t);
      falls++;
      low = 1;
    end
    else
      low++;
    prev_oe <= data_oe_out;
    prev_act <= conv_active_out;
  end

  initial
  begin
    int i;
    logic [15:0] e;
    void'($urandom(32'h17374c07));
    tmr = 16'($urandom_range(3, 0));
    ins[0] = {4'($urandom_range(15, 4)), 12'h200};
    ins[1] = {4'($urandom_range(15, 4)), 12'h100};
    ins[2] = {4'($urandom_range(15, 4)), 12'h002};
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    for (i = 0; i < 3; i++)
      i_host.strobe(1'h1, 4'(i), ins[i], 1'h0, 1'h0);
    i_host.strobe(1'h1, asr_pkg::ADDR_TIMER, tmr, 1'h0, 1'h0);
    i_host.strobe(1'h1, asr_pkg::ADDR_INT_EN, 16'hf804, 1'h0, 1'h0);
    i_host.strobe(1'h1, asr_pkg::ADDR_CONFIG, 16'h0021, 1'h0, 1'h0);
    wait_for(rises, 21);
    i_host.strobe(1'h1, asr_pkg::ADDR_CONFIG, 16'h0001, 1'h0, 1'h0);
    tag_ip = 1'h0;
    // Start dropped mid-conversion; that result must still land
    wait_for(rises, 36);
    i_host.strobe(1'h1, asr_pkg::ADDR_CONFIG, 16'h0000, 1'h0, 1'h0);
    wait_for(falls, 36);
    repeat (300) @(posedge clk_sys_in);
    check_cnt(rises, 36);
    // Fill count first, then no more reads than results held
    note({5'(res_q.size()), 3'(36 % 3), 8'h0}, 16'hff00);
    i_host.strobe(1'h0, asr_pkg::ADDR_INT_STAT, 16'h0, 1'h0, 1'h0);
    check({15'h0, int_n_out}, 16'h1);
    for (i = 0; i < 30; i++)
    begin
      note(res_q.pop_front(), 16'hffff);
      i_host.strobe(1'h0, asr_pkg::ADDR_FIFO, 16'h0, 1'h0, 1'h0);
    end
    for (i = 0; i < 2; i++)
    begin
      e = res_q.pop_front();
      note({8'h0, e[7:0]}, 16'hffff);
      i_host.strobe(1'h0, asr_pkg::ADDR_FIFO, 16'h0, 1'h1, 1'h0);
      note({8'h0, e[15:8]}, 16'hffff);
      i_host.strobe(1'h0, asr_pkg::ADDR_FIFO, 16'h0, 1'h1, 1'h1);
    end
    check({15'h0, dma_req_out}, 16'h0);
    check_cnt(exp_q.size(), 0);
    end_sim();
  end
endmodule
